// ### verilog/i2c_port_pkg.sv
// Constants and carrier types for the two-wire slave register port.
// Assumes a single 40 MHz system clock shared by all users of the package.
package i2c_port_pkg;
	localparam int        CLK_PERIOD_NS = 25;
	// Spike widths that the input filters suppress in each speed setting.
	localparam int        SPIKE_FS_NS   = 50;
	localparam int        SPIKE_HS_NS   = 10;
	localparam logic [2:0] SPIKE_FS_CYC =
		3'((SPIKE_FS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] SPIKE_HS_CYC =
		3'((SPIKE_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Fixed upper address nibble used when the mode select pin is low.
	localparam logic [3:0] ADDR_HI_FIXED = 4'h5;
	// Master code prefix 00001xxx that announces high-speed transfers.
	localparam logic [4:0] MCODE_PFX     = 5'h01;
	localparam logic [6:0] SLAVE_ADDR_RST = 7'h00;
	localparam logic [7:0] BYTE_RST      = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] IDX_SLAVE     = 2'h0;
	localparam logic [1:0] IDX_REGADDR   = 2'h1;
	localparam logic [1:0] IDX_DATA      = 2'h2;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_RX    = 6'b000010,
		ST_ACK   = 6'b000100,
		ST_TX    = 6'b001000,
		ST_RACK  = 6'b010000,
		ST_MNACK = 6'b100000
	} port_state_t;

	// Register access request towards the device's register file.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
endpackage : i2c_port_pkg

// ### verilog/i2c_slave_register_port.sv
// Two-wire slave port giving a bus master access to internal registers.
// Assumes the register file answers reg_rdata within one cycle of a read
// pulse and that SCL, SDA and all straps are asynchronous pins.
//
// Function
// R1: Address fixed from straps after reset release.
// R2: Mode pin low: address 0101 plus pins 2..0.
// R3: Mode pin high: bit6 zero, pins 5..0.
// R4: Straps latched once, ignored until next reset.
// R5: Write frame: all data to one register.
// R6: Host sets register address before reading.
// R7: Read frame repeats same register, no increment.
// R8: High-speed transfers supported, slower masters too.
// R9: Master code 00001xxx, never acknowledged, enters HS.
// R10: After repeated start, matching address is acknowledged.
// R11: HS kept over repeated starts, left on stop.
// R12: Fast mode after reset.
// R13: HS switches filters and output slope control.
// R14: Force bit keeps HS permanently, no master code.
// R15: Host forces HS only on a quiet bus.
// R16: Without master code stay in fast mode.
// R17: Slave only, never drives clock.
// R18: Bytes MSB first, receiver acknowledges each.
// R19: Foreign address: release SDA, ignore the frame.
`timescale 1ns/100ps
module i2c_slave_register_port (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	input  wire logic                   powerdown_reset_pin,
	input  wire logic                   address_mode_select_pin,
	input  wire logic [5:0]             addr_pins,
	input  wire logic                   force_high_speed_bit,
	output i2c_port_pkg::reg_req_t      reg_req,
	input  wire logic [7:0]             reg_rdata,
	output logic [6:0]                  slave_addr,
	output logic                        addr_valid,
	output logic                        filter_hs,
	output logic                        slope_hs
);
	import i2c_port_pkg::*;

	function automatic logic [6:0] own_addr(input logic mode,
	                                        input logic [5:0] pins);
		own_addr = mode ? {1'b0, pins} : {ADDR_HI_FIXED, pins[2:0]};
	endfunction : own_addr

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	logic [9:0]  pin_s1;
	logic [9:0]  pin_s2;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 10'h3ff;
			pin_s2 <= 10'h3ff;
		end else begin
			pin_s1 <= {scl_in, sda_in, powerdown_reset_pin,
			           address_mode_select_pin, addr_pins};
			pin_s2 <= pin_s1;
		end
	end
	logic        scl_s;
	logic        sda_s;
	logic        pd_n_s;
	logic        mode_s;
	logic [5:0]  adr_s;
	assign scl_s  = pin_s2[9];
	assign sda_s  = pin_s2[8];
	assign pd_n_s = pin_s2[7];
	assign mode_s = pin_s2[6];
	assign adr_s  = pin_s2[5:0];

	////////////////////////////////////////////////////////////////////
	// Strap latch: taken once after either reset is released.
	// The synchronisers show their idle values for two edges after reset,
	// so the straps are taken only once real pin samples have arrived.
	logic [1:0]  sync_fill_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_fill_reg <= 2'h0;
		end else begin
			sync_fill_reg <= {sync_fill_reg[0], 1'b1};
		end
	end
	logic [6:0]  slave_addr_reg;
	logic        latched_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched_reg    <= 1'b0;
			slave_addr_reg <= SLAVE_ADDR_RST;
		end else if (!pd_n_s) begin
			latched_reg    <= 1'b0;
		end else if (!latched_reg && sync_fill_reg[1]) begin
			latched_reg    <= 1'b1; // see R1
			slave_addr_reg <= own_addr(mode_s, adr_s); // see R2 see R3
		end
	end
	assign slave_addr = slave_addr_reg; // see R4
	assign addr_valid = latched_reg;

	////////////////////////////////////////////////////////////////////
	// Spike filters whose width follows the speed setting.
	logic [1:0]  line_f;
	logic [2:0]  flt_cnt [2];
	logic        filter_hs_reg;
	logic [2:0]  flt_lim;
	assign flt_lim = filter_hs_reg ? SPIKE_HS_CYC : SPIKE_FS_CYC; // see R13
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_f     <= 2'h3;
			flt_cnt[0] <= 3'h0;
			flt_cnt[1] <= 3'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 1 ? scl_s : sda_s) == line_f[i]) begin
					flt_cnt[i] <= 3'h0;
				end else if (flt_cnt[i] + 3'h1 >= flt_lim) begin
					line_f[i]  <= ~line_f[i];
					flt_cnt[i] <= 3'h0;
				end else begin
					flt_cnt[i] <= flt_cnt[i] + 3'h1;
				end
			end
		end
	end
	logic        scl_f;
	logic        sda_f;
	logic        scl_d;
	logic        sda_d;
	assign scl_f = line_f[1];
	assign sda_f = line_f[0];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	assign scl_rise = scl_f && !scl_d;
	assign scl_fall = !scl_f && scl_d;
	assign start_ev = scl_f && scl_d && sda_d && !sda_f;
	assign stop_ev  = scl_f && scl_d && !sda_d && sda_f;

	////////////////////////////////////////////////////////////////////
	// Bus state machine.
	port_state_t st_reg;
	logic [7:0]  shift_reg;
	logic [3:0]  bit_cnt_reg;
	logic [1:0]  byte_idx_reg;
	logic        rw_reg;
	logic        mack_reg;
	logic        sda_oe_n_reg;
	logic [7:0]  rdata_hold_reg;
	logic        byte_end;
	logic        addr_hit;
	logic        is_mcode;
	assign byte_end = (st_reg == ST_RX) && scl_fall &&
	                  (bit_cnt_reg == BITS_PER_BYTE);
	assign addr_hit = latched_reg && (shift_reg[7:1] == slave_addr_reg);
	assign is_mcode = shift_reg[7:3] == MCODE_PFX;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg       <= ST_IDLE;
			shift_reg    <= BYTE_RST;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= IDX_SLAVE;
			rw_reg       <= 1'b0;
			mack_reg     <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else if (!pd_n_s || stop_ev) begin
			st_reg       <= ST_IDLE;
			sda_oe_n_reg <= 1'b1;
		end else if (start_ev) begin
			st_reg       <= ST_RX;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= IDX_SLAVE;
			sda_oe_n_reg <= 1'b1;
		end else begin
			case (st_reg)
			ST_RX: begin
				if (scl_rise) begin
					shift_reg   <= {shift_reg[6:0], sda_f}; // see R18
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (byte_end) begin
					if (byte_idx_reg != IDX_SLAVE) begin
						st_reg       <= ST_ACK; // see R5
						sda_oe_n_reg <= 1'b0;
					end else if (is_mcode) begin
						st_reg <= ST_MNACK; // see R9
					end else if (addr_hit) begin
						st_reg       <= ST_ACK; // see R10
						sda_oe_n_reg <= 1'b0;
						rw_reg       <= shift_reg[0];
					end else begin
						st_reg <= ST_IDLE; // see R19
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					bit_cnt_reg <= 4'h0;
					if (byte_idx_reg != IDX_DATA) begin
						byte_idx_reg <= byte_idx_reg + 2'h1;
					end
					if (rw_reg && byte_idx_reg == IDX_SLAVE) begin
						st_reg       <= ST_TX; // see R7
						shift_reg    <= rdata_hold_reg;
						sda_oe_n_reg <= rdata_hold_reg[7];
					end else begin
						st_reg       <= ST_RX;
						sda_oe_n_reg <= 1'b1;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == BITS_PER_BYTE - 4'h1) begin
						st_reg       <= ST_RACK;
						sda_oe_n_reg <= 1'b1;
					end else begin
						shift_reg    <= {shift_reg[6:0], 1'b0};
						sda_oe_n_reg <= shift_reg[6]; // see R18
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					mack_reg <= !sda_f;
				end else if (scl_fall) begin
					bit_cnt_reg <= 4'h0;
					if (mack_reg) begin
						st_reg       <= ST_TX;
						shift_reg    <= rdata_hold_reg;
						sda_oe_n_reg <= rdata_hold_reg[7];
					end else begin
						st_reg <= ST_IDLE;
					end
				end
			end
			ST_MNACK: begin
				if (scl_fall) begin
					st_reg <= ST_IDLE;
				end
			end
			default: begin
				st_reg       <= ST_IDLE;
				sda_oe_n_reg <= 1'b1;
			end
			endcase
		end
	end
	assign sda_oe_n = sda_oe_n_reg;

	// The pad only ever pulls low; the clock line is never driven.
	logic        sda_out_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0; // see R17
		end
	end
	assign sda_out = sda_out_reg;

	////////////////////////////////////////////////////////////////////
	// Register access requests.
	reg_req_t    reg_req_reg;
	logic        rd_pend_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_req_reg    <= '0;
			rd_pend_reg    <= 1'b0;
			rdata_hold_reg <= BYTE_RST;
		end else begin
			reg_req_reg.wr <= 1'b0;
			reg_req_reg.rd <= 1'b0;
			rd_pend_reg    <= reg_req_reg.rd;
			if (rd_pend_reg) begin
				rdata_hold_reg <= reg_rdata;
			end
			if (byte_end && byte_idx_reg == IDX_REGADDR) begin
				reg_req_reg.addr <= shift_reg; // see R6
			end
			if (byte_end && byte_idx_reg == IDX_DATA) begin
				reg_req_reg.wdata <= shift_reg;
				reg_req_reg.wr    <= 1'b1; // see R5
			end
			if (byte_end && byte_idx_reg == IDX_SLAVE && addr_hit &&
			    !is_mcode && shift_reg[0]) begin
				reg_req_reg.rd <= 1'b1; // see R7
			end
			if (st_reg == ST_RACK && scl_rise && !sda_f) begin
				reg_req_reg.rd <= 1'b1;
			end
		end
	end
	assign reg_req = reg_req_reg;

	////////////////////////////////////////////////////////////////////
	// Speed mode: fast after reset, high speed after a master code.
	logic        hs_reg;
	logic        slope_hs_reg;
	logic        hs_next;
	assign hs_next = (!pd_n_s || stop_ev) ? 1'b0 :
	                 (st_reg == ST_MNACK && scl_fall) ? 1'b1 : hs_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hs_reg        <= 1'b0; // see R12
			filter_hs_reg <= 1'b0;
			slope_hs_reg  <= 1'b0;
		end else begin
			hs_reg        <= hs_next; // see R11 see R16
			filter_hs_reg <= hs_next || force_high_speed_bit; // see R14
			slope_hs_reg  <= hs_next || force_high_speed_bit; // see R13
		end
	end
	assign filter_hs = filter_hs_reg; // see R8
	assign slope_hs  = slope_hs_reg;

	////////////////////////////////////////////////////////////////////
	// Assertions.
	property p_fixed_hi;
		@(posedge clk) disable iff (rst)
		$rose(latched_reg) && !$past(mode_s) |->
			slave_addr_reg[6:3] == ADDR_HI_FIXED;
	endproperty
	a_fixed_hi: assert property (p_fixed_hi) // see R2
		else $error("fixed address nibble wrong");
	property p_pin_addr;
		@(posedge clk) disable iff (rst)
		$rose(latched_reg) && $past(mode_s) |->
			slave_addr_reg == {1'b0, $past(adr_s)};
	endproperty
	a_pin_addr: assert property (p_pin_addr) // see R3
		else $error("pin address wrong");
	property p_addr_hold;
		@(posedge clk) disable iff (rst)
		latched_reg && $past(latched_reg) |-> $stable(slave_addr_reg);
	endproperty
	a_addr_hold: assert property (p_addr_hold) // see R4
		else $error("address changed after latch");
	property p_mcode_nack;
		@(posedge clk) disable iff (rst || !pd_n_s)
		byte_end && byte_idx_reg == IDX_SLAVE && is_mcode |=>
			sda_oe_n_reg [*8];
	endproperty
	a_mcode_nack: assert property (p_mcode_nack) // see R9
		else $error("master code acknowledged");
	property p_hs_keep;
		@(posedge clk) disable iff (rst || !pd_n_s)
		hs_reg && !stop_ev |=> hs_reg;
	endproperty
	a_hs_keep: assert property (p_hs_keep) // see R11
		else $error("high speed lost without stop");
	property p_hs_leave;
		@(posedge clk) disable iff (rst)
		stop_ev |=> !hs_reg;
	endproperty
	a_hs_leave: assert property (p_hs_leave) // see R11
		else $error("high speed kept after stop");
	property p_force;
		@(posedge clk) disable iff (rst)
		force_high_speed_bit |=> filter_hs_reg && slope_hs_reg;
	endproperty
	a_force: assert property (p_force) // see R14
		else $error("force bit ignored");
	property p_foreign;
		@(posedge clk) disable iff (rst || !pd_n_s)
		byte_end && byte_idx_reg == IDX_SLAVE && !is_mcode && !addr_hit
		|=> st_reg == ST_IDLE && sda_oe_n_reg;
	endproperty
	a_foreign: assert property (p_foreign) // see R19
		else $error("foreign frame answered");
	property p_ack_data;
		@(posedge clk) disable iff (rst || !pd_n_s)
		byte_end && byte_idx_reg != IDX_SLAVE && !start_ev && !stop_ev
		|=> !sda_oe_n_reg ##1 reg_req_reg.addr == $past(reg_req_reg.addr);
	endproperty
	a_ack_data: assert property (p_ack_data) // see R5
		else $error("data byte not acknowledged");
	// The data line is only pulled while acknowledging or transmitting.
	property p_slave_drive;
		@(posedge clk) disable iff (rst)
		!sda_oe_n_reg |-> sda_out_reg == 1'b0 &&
			(st_reg == ST_ACK || st_reg == ST_TX);
	endproperty
	a_slave_drive: assert property (p_slave_drive) // see R17
		else $error("data line driven outside a slave phase");
	c_write: cover property (@(posedge clk) reg_req_reg.wr);
	c_read:  cover property (@(posedge clk) st_reg == ST_TX);
	c_hs:    cover property (@(posedge clk) $rose(hs_reg));
endmodule : i2c_slave_register_port

// ### tb/i2c_host_model.sv
// Behavioural two-wire bus master driving SCL and an open-drain SDA.
// Assumes the bench forms the wired-AND line with a pull-up.
`timescale 1ns/100ps
module i2c_host_model #(
	parameter int LOW_CYC  = 6,
	parameter int HIGH_CYC = 2
) (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_rel
);
	initial begin
		scl     = 1'b1;
		sda_rel = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// One bit takes 200 ns. The low phase is the longer one because the
	// port answers about five clocks after it sees the clock line fall.
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic start;
		wt(1);
		sda_rel = 1'b1;
		wt(LOW_CYC - 1);
		scl = 1'b1;
		wt(HIGH_CYC);
		sda_rel = 1'b0;
		wt(HIGH_CYC);
		scl = 1'b0;
	endtask : start
	task automatic stop;
		wt(1);
		sda_rel = 1'b0;
		wt(LOW_CYC - 1);
		scl = 1'b1;
		wt(HIGH_CYC);
		sda_rel = 1'b1;
		wt(HIGH_CYC);
	endtask : stop
	// Data changes one clock after the fall and is sampled late high.
	task automatic bit_cyc(input logic b, output logic r);
		wt(1);
		sda_rel = b;
		wt(LOW_CYC - 1);
		scl = 1'b1;
		wt(HIGH_CYC - 1);
		r = sda_line;
		wt(1);
		scl = 1'b0;
	endtask : bit_cyc
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(d[i], r);
		end
		bit_cyc(1'b1, r);
		ack = ~r;
	endtask : send
	task automatic recv(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b1, r);
			d[i] = r;
		end
		bit_cyc(~ack, r);
	endtask : recv
endmodule : i2c_host_model

// ### tb/i2c_slave_register_port_test.sv
// Self-checking bench for the two-wire slave register port.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/100ps
module i2c_slave_register_port_test;
	import i2c_port_pkg::*;
	logic                   clk;
	logic                   rst;
	logic                   pd_n;
	logic                   mode;
	logic [5:0]             pins;
	logic                   force_hs;
	logic [7:0]             reg_rdata;
	logic                   sda_out;
	logic                   sda_oe_n;
	logic                   scl;
	logic                   host_rel;
	wire                    sda_line;
	reg_req_t               reg_req;
	logic [6:0]             slave_addr;
	logic                   addr_valid;
	logic                   filter_hs;
	logic                   slope_hs;
	logic                   ack;
	logic [7:0]             d;
	int                     num_errors;
	int                     checks;
	int                     wr_cnt;
	int                     rd_cnt;
	logic [7:0]             wr_addr;
	logic [7:0]             wr_data;
	// Pull-up wired-AND of both open-drain drivers.
	assign sda_line = host_rel & (sda_oe_n | sda_out);
	initial begin
		clk = 1'b0;
		wr_cnt = 0;
		rd_cnt = 0;
	end
	always #12.5 clk = ~clk;
	i2c_host_model u_host (
		.clk      (clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_rel  (host_rel)
	);
	i2c_slave_register_port DUT (
		.clk                     (clk),
		.rst                     (rst),
		.scl_in                  (scl),
		.sda_in                  (sda_line),
		.sda_out                 (sda_out),
		.sda_oe_n                (sda_oe_n),
		.powerdown_reset_pin     (pd_n),
		.address_mode_select_pin (mode),
		.addr_pins               (pins),
		.force_high_speed_bit    (force_hs),
		.reg_req                 (reg_req),
		.reg_rdata               (reg_rdata),
		.slave_addr              (slave_addr),
		.addr_valid              (addr_valid),
		.filter_hs               (filter_hs),
		.slope_hs                (slope_hs)
	);
	////////////////////////////////////////////////////////////////////////
	// Register file stand-in: contents derived from the address.
	always @(negedge clk) reg_rdata = reg_req.addr ^ 8'h3c;
	// Pulses are counted mid-cycle, away from the edge that launches them.
	always @(negedge clk) begin
		if (reg_req.wr === 1'b1) begin
			wr_cnt++;
			wr_addr = reg_req.addr;
			wr_data = reg_req.wdata;
		end
		if (reg_req.rd === 1'b1) begin
			rd_cnt++;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic wait_valid;
		int n;
		n = 0;
		while (addr_valid !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 20) begin
				num_errors++;
				wrap_up();
			end
		end
	endtask : wait_valid
	task automatic wframe(input logic [6:0] a, input logic [7:0] ra);
		u_host.start();
		u_host.send({a, 1'b0}, ack);
		u_host.send(ra, ack);
	endtask : wframe
	////////////////////////////////////////////////////////////////////////
	initial begin
		num_errors = 0;
		checks = 0;
		rst = 1'b1;
		pd_n = 1'b1;
		mode = 1'b0;
		pins = 6'h2a;
		force_hs = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		wait_valid();
		chk(8'(slave_addr), 8'({ADDR_HI_FIXED, 3'h2}));
		chk(8'({filter_hs, slope_hs}), 8'h00);
		pins = 6'h15;
		repeat (6) @(negedge clk);
		chk(8'(slave_addr), 8'h2a);
		$display("test strap done");
		wframe(7'h2a, 8'h09);
		chk(8'(ack), 8'h01);
		u_host.send(8'ha5, ack);
		chk(8'(wr_data), 8'ha5);
		u_host.send(8'h5a, ack);
		u_host.stop();
		chk(8'(wr_cnt), 8'h02);
		chk(wr_addr, 8'h09);
		chk(wr_data, 8'h5a);
		chk(8'({filter_hs, slope_hs}), 8'h00);
		$display("test write done");
		wframe(7'h2a, 8'h11);
		u_host.stop();
		u_host.start();
		u_host.send({7'h2a, 1'b1}, ack);
		chk(8'(ack), 8'h01);
		u_host.recv(d, 1'b1);
		chk(d, 8'h11 ^ 8'h3c);
		u_host.recv(d, 1'b0);
		chk(d, 8'h11 ^ 8'h3c);
		u_host.stop();
		chk(8'(rd_cnt), 8'h02);
		$display("test read done");
		wframe(7'h2b, 8'h00);
		chk(8'(ack), 8'h00);
		u_host.stop();
		chk(8'(wr_cnt), 8'h02);
		$display("test foreign done");
		u_host.start();
		u_host.send(8'h0b, ack);
		chk(8'(ack), 8'h00);
		repeat (8) @(negedge clk);
		chk(8'({filter_hs, slope_hs}), 8'h03);
		wframe(7'h2a, 8'h22);
		chk(8'(ack), 8'h01);
		u_host.start();
		u_host.send({7'h2a, 1'b0}, ack);
		chk(8'({ack, filter_hs}), 8'h03);
		u_host.stop();
		repeat (6) @(negedge clk);
		chk(8'({filter_hs, slope_hs}), 8'h00);
		$display("test high speed done");
		force_hs = 1'b1;
		repeat (4) @(negedge clk);
		chk(8'({filter_hs, slope_hs}), 8'h03);
		wframe(7'h2a, 8'h33);
		chk(8'(ack), 8'h01);
		u_host.stop();
		force_hs = 1'b0;
		$display("test force done");
		pd_n = 1'b0;
		mode = 1'b1;
		pins = 6'h2d;
		repeat (5) @(negedge clk);
		chk(8'(addr_valid), 8'h00);
		pd_n = 1'b1;
		wait_valid();
		chk(8'(slave_addr), 8'h2d);
		wframe(7'h2d, 8'h44);
		chk(8'(ack), 8'h01);
		u_host.stop();
		$display("test wide address done");
		wrap_up();
	end
endmodule : i2c_slave_register_port_test
